/* File: pkg/cse_map.svh */
`ifndef CSE_MAP_SVH
`define CSE_MAP_SVH
// Register offsets (byte addresses, word aligned)
`define CSE_OFF_CTRL      4'h0
`define CSE_OFF_STATUS    4'h4
`define CSE_OFF_RESULT    4'h8
`define CSE_OFF_DECODE    4'hC
// Control fields
`define CSE_CTRL_START    0
`define CSE_CTRL_MODE     1
`define CSE_CTRL_EXT      2
// Status fields
`define CSE_STAT_BUSY     0
`define CSE_STAT_DONE     1
// Reset values
`define CSE_CTRL_RST      3'h0
`define CSE_DECODE_RST    9'h000
// Conversion length in clock pulses
`define CSE_CONV_CLOCKS   4'h9
// Settle time between conversion clocks, ns, and in sys_clk cycles
`define CSE_SETTLE_NS     40
`define CSE_CLK_MHZ       250
`define CSE_SETTLE_CYC    ((`CSE_SETTLE_NS * `CSE_CLK_MHZ + 999) / 1000)
`endif

/* File: pkg/cse_pkg.sv */
package cse_pkg;
	typedef enum logic [2:0] {
		CSE_IDLE   = 3'b000,
		CSE_SIGN   = 3'b001,
		CSE_TRIAL  = 3'b011,
		CSE_FINISH = 3'b010
	} cse_state_type;
	typedef logic [7:0] cse_code_type;
endpackage : cse_pkg

/* File: core/cse_tick.sv */
`timescale 1ns/1ps
`include "cse_map.svh"
// Conversion clock enable: one pulse every settle period while running
module cse_tick
	import cse_pkg::*;
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic resetn,
	// Control
	input  wire logic run,
	output logic      tick
);
	logic [7:0] count_reg;

	always_ff @(posedge sys_clk) begin
		if (!resetn || !run) begin
			count_reg <= 8'h00;
		end else if (count_reg == 8'(`CSE_SETTLE_CYC - 1)) begin
			count_reg <= 8'h00;
		end else begin
			count_reg <= count_reg + 8'h01;
		end
	end

	assign tick = run && (count_reg == 8'(`CSE_SETTLE_CYC - 1));
endmodule : cse_tick

/* File: core/cse_ctrl.sv */
`timescale 1ns/1ps
`include "cse_map.svh"
// Functional notes
// - Decode-only extended range uses encode/decode select as ninth bit.
// - Sign picks polarity, three chord bits pick chord; four step bits pick step.
// - Polarity is resolved first, before any magnitude bit.
// - First clock clears register MSB and sets all other bits to one.
// - First clock drives encode/decode select low to compare against ground.
// - Comparator passes an XOR; inverted when negative, held low for sign.
// - Magnitude code is uncomplemented for either polarity.
// - Second clock restores encode select and loads sign into MSB.
// - Conversion takes nine clocks ending with an eight-bit code.
// - Analog input is held by sample-and-hold during conversion.
module cse_ctrl
	import cse_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	// Avalon-MM slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Converter logic inputs
	output logic             sign_select,
	output logic [2:0]       chord_select,
	output logic [3:0]       step_select,
	output logic             encode_select,
	// Comparator and sample-and-hold
	input  wire logic        comparator_high,
	output logic             sample_hold
);
	cse_state_type state_reg;
	logic [7:0]    sar_reg;
	logic [7:0]    result_reg;
	logic [8:0]    decode_reg;
	logic [2:0]    ctrl_reg;
	logic [3:0]    clk_count_reg;
	logic          negative_reg;
	logic          encode_reg;
	logic          done_reg;
	logic          rd_pending_reg;
	logic          tick;
	logic          serial_in;
	logic          running;
	logic          start_pulse;
	logic          clear_done;

	// Position of the bit under trial after clock n
	function automatic logic [2:0] trial_pos(input logic [3:0] n);
		trial_pos = 3'(4'h8 - n);
	endfunction : trial_pos

	// --------------------------------------------------------------
	// Bus access
	// --------------------------------------------------------------
	// Reads take one wait cycle so read data come from a flip-flop
	assign avs_waitrequest = avs_read && !rd_pending_reg;
	assign start_pulse = avs_write && avs_address == `CSE_OFF_CTRL
		&& avs_byteenable[0] && avs_writedata[`CSE_CTRL_START]
		&& state_reg == CSE_IDLE;
	assign clear_done = avs_read && rd_pending_reg
		&& avs_address == `CSE_OFF_RESULT;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			rd_pending_reg <= 1'b0;
		end else begin
			rd_pending_reg <= avs_read && !rd_pending_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !rd_pending_reg) begin
			unique case (avs_address)
				`CSE_OFF_CTRL:   avs_readdata <= {29'h0, ctrl_reg};
				`CSE_OFF_STATUS: avs_readdata <= {30'h0, done_reg,
					state_reg != CSE_IDLE};
				`CSE_OFF_RESULT: avs_readdata <= {24'h0, result_reg};
				`CSE_OFF_DECODE: avs_readdata <= {23'h0, decode_reg};
				default:         avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl_reg   <= `CSE_CTRL_RST;
			decode_reg <= `CSE_DECODE_RST;
		end else if (avs_write && avs_byteenable[0]) begin
			if (avs_address == `CSE_OFF_CTRL) begin
				ctrl_reg <= {avs_writedata[`CSE_CTRL_EXT],
					avs_writedata[`CSE_CTRL_MODE], 1'b0};
			end else if (avs_address == `CSE_OFF_DECODE) begin
				decode_reg[7:0] <= avs_writedata[7:0];
				if (avs_byteenable[1]) begin
					decode_reg[8] <= avs_writedata[8];
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Conversion sequencer
	// --------------------------------------------------------------
	assign running = state_reg != CSE_IDLE;

	cse_tick u_tick (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.run     (running),
		.tick    (tick)
	);

	// Sign held low while polarity resolves, then inverts
	assign serial_in = comparator_high
		^ (negative_reg && state_reg != CSE_SIGN);

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg     <= CSE_IDLE;
			sar_reg       <= 8'h00;
			clk_count_reg <= 4'h0;
			encode_reg    <= 1'b1;
		end else begin
			unique case (state_reg)
				CSE_IDLE: if (start_pulse) begin
					sar_reg       <= 8'h7F;
					encode_reg    <= 1'b0;
					clk_count_reg <= 4'h1;
					state_reg     <= CSE_SIGN;
				end
				CSE_SIGN: if (tick) begin
					sar_reg[7]    <= serial_in;
					sar_reg[6]    <= 1'b0;
					encode_reg    <= 1'b1;
					clk_count_reg <= 4'h2;
					state_reg     <= CSE_TRIAL;
				end
				CSE_TRIAL: if (tick) begin
					// Trial bit low, lower bits high: the converter shows
					// the top of the lower half, so a win sets the bit
					sar_reg[trial_pos(clk_count_reg)] <= serial_in;
					clk_count_reg <= clk_count_reg + 4'h1;
					if (clk_count_reg == `CSE_CONV_CLOCKS - 4'h1) begin
						state_reg <= CSE_FINISH;
					end else begin
						sar_reg[trial_pos(clk_count_reg) - 3'h1] <= 1'b0;
					end
				end
				CSE_FINISH: begin
					state_reg     <= CSE_IDLE;
					clk_count_reg <= 4'h0;
				end
			endcase
		end
	end

	// Polarity remembered so magnitude decisions flip for negatives
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			negative_reg <= 1'b0;
		end else if (state_reg == CSE_SIGN && tick) begin
			negative_reg <= !comparator_high;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			result_reg <= 8'h00;
			done_reg   <= 1'b0;
		end else if (state_reg == CSE_FINISH) begin
			result_reg <= sar_reg;
			done_reg   <= 1'b1;                 // set wins over clear
		end else if (clear_done) begin
			done_reg   <= 1'b0;
		end
	end

	// Input frozen for the whole conversion
	assign sample_hold = running;

	// --------------------------------------------------------------
	// Converter pins
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			sign_select   <= 1'b0;
			chord_select  <= 3'h0;
			step_select   <= 4'h0;
			encode_select <= 1'b0;
		end else if (running) begin
			// Encode loop: SAR bits drive the converter directly
			{sign_select, chord_select, step_select} <= sar_reg;
			encode_select <= encode_reg;
		end else begin
			// Decode: code from software; all-ones is full scale
			{sign_select, chord_select, step_select} <= decode_reg[7:0];
			// Ninth bit adds the half step in extended range
			encode_select <= ctrl_reg[2] ? decode_reg[8]
				: ctrl_reg[1];
		end
	end
endmodule : cse_ctrl

/* File: tb/cse_checker.sv */
`timescale 1ns/1ps
`include "cse_map.svh"
module cse_checker (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       resetn,
	// Converter pins
	input wire logic       sign_select,
	input wire logic [2:0] chord_select,
	input wire logic [3:0] step_select,
	input wire logic       encode_select,
	input wire logic       comparator_high,
	input wire logic       sample_hold
);
	logic [6:0] mag;
	logic [6:0] mag_q;
	logic [6:0] fell;
	logic [6:0] rose;
	logic [7:0] cnt_reg;
	assign mag = {chord_select, step_select};
	assign fell = mag_q & ~mag;
	assign rose = mag & ~mag_q;
	always_ff @(posedge sys_clk) begin
		mag_q <= mag;
	end
	always_ff @(posedge sys_clk)
		cnt_reg <= sample_hold ? cnt_reg + 8'h01 : 8'h00;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	sequence s_go; $rose(sample_hold); endsequence
	sequence s_back; $rose(encode_select) && sample_hold; endsequence
	// Pin change inside magnitude phase, clear of both ends
	sequence s_mid;
		sample_hold[*3] ##0 $past(encode_select) && $past(encode_select, 2);
	endsequence
	// One magnitude step, last one included
	sequence s_step;
		$past(sample_hold) && $past(encode_select) && encode_select;
	endsequence
	a_first_clk: assert property (
		s_go |=> !sign_select && !encode_select && mag == 7'h7f)
		else $error("first clock pins");
	a_gnd_phase: assert property (
		s_go |=> !encode_select[*5] ##[1:14] encode_select)
		else $error("ground phase");
	a_sign_cmp: assert property (
		s_back |-> sign_select == $past(comparator_high, 2))
		else $error("sign not from comparator");
	a_sign_hold: assert property (
		s_mid |-> $past(sign_select) == $past(sign_select, 2))
		else $error("sign moved");
	a_trial_ord: assert property (
		s_step |-> $onehot0(fell)
		&& (rose == 7'h00 || (rose >> 1) == fell))
		else $error("bit out of trial order");
	a_bit_cmp: assert property (
		s_step ##0 mag != mag_q
		|-> (rose != 7'h00) == ($past(comparator_high, 2) == sign_select))
		else $error("bit decided wrongly");
	a_conv_len: assert property (
		$fell(sample_hold) |-> cnt_reg
		== 8'((`CSE_CONV_CLOCKS - 1) * `CSE_SETTLE_CYC + 1))
		else $error("conversion length");
	a_held: assert property (s_go |-> sample_hold[*8])
		else $error("hold dropped");
endmodule : cse_checker

/* File: tb/cse_conv_model.sv */
`timescale 1ns/1ps
module cse_conv_model (
	// Converter inputs
	input wire logic               sign_select,
	input wire logic         [2:0] chord_select,
	input wire logic         [3:0] step_select,
	input wire logic               encode_select,
	// Analog side
	input wire logic signed [15:0] analog,
	output logic                   comparator_high
);
	int lvl;
	// Doubled units keep the half step whole
	always_comb begin
		if (chord_select == 3'h0)
			lvl = 4 * step_select + 4;
		else
			lvl = (2 * step_select + 34) << chord_select;
		if (!encode_select)
			lvl = 0;
		comparator_high = analog > (sign_select ? lvl : -lvl);
	end
endmodule : cse_conv_model

/* File: tb/cse_ctrl_tb_top.sv */
`timescale 1ns/1ps
`include "cse_map.svh"
module cse_ctrl_tb_top;
	logic               sys_clk = 1'b0;
	logic               resetn = 1'b0;
	logic        [3:0]  avs_address = 4'h0;
	logic               avs_read = 1'b0;
	logic               avs_write = 1'b0;
	logic        [31:0] avs_writedata = 32'h0000_0000;
	logic        [31:0] avs_readdata;
	logic        [31:0] q;
	logic               avs_waitrequest;
	logic               sign_select;
	logic        [2:0]  chord_select;
	logic        [3:0]  step_select;
	logic               encode_select;
	logic               comparator_high;
	logic               sample_hold;
	logic signed [15:0] analog = 16'sh0000;
	logic        [8:0]  d;
	int                 bad_count = 0;
	int                 n_compared = 0;
	logic signed [15:0] corner [5] = '{16'sh0001, -16'sh0001, 16'sh2711,
		-16'sh2711, 16'sh0003};
	always #2 sys_clk = ~sys_clk;
	cse_ctrl u_cse_ctrl (.sys_clk, .resetn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .sign_select, .chord_select, .step_select,
		.encode_select, .comparator_high, .sample_hold);
	cse_conv_model u_cse_conv_model (.sign_select, .chord_select,
		.step_select, .encode_select, .analog, .comparator_high);
	task check(input logic ok, input string m);
		n_compared++;
		if (!ok) begin
			bad_count++;
			$display("CHECK FAILED %0t: %s", $time, m);
		end
	endtask : check
	task bus(input logic [3:0] a, input logic w, input logic [31:0] wd);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	function automatic logic [7:0] exp_code(input logic signed [15:0] a);
		int m;
		int g;
		int l;
		m = 127;
		g = (a > 0) ? a : -a;
		// Trial bit low with lower bits high; a win puts it back
		for (int b = 6; b >= 0; b--) begin
			m = m & ~(1 << b);
			l = (m >> 4 == 0) ? 4 * (m & 15) + 4
				: (2 * (m & 15) + 34) << (m >> 4);
			if ((a > 0) ? (g > l) : (g >= l))
				m = m | (1 << b);
		end
		return {a > 0, m[6:0]};
	endfunction : exp_code
	task convert(input logic signed [15:0] a);
		int i;
		analog <= a;
		bus(`CSE_OFF_CTRL, 1'b1, 32'h0000_0001);
		bus(`CSE_OFF_STATUS, 1'b0, 32'h0000_0000);
		check(q[`CSE_STAT_BUSY] === 1'b1 && q[`CSE_STAT_DONE] === 1'b0,
			"busy");
		i = 0;
		do begin
			bus(`CSE_OFF_STATUS, 1'b0, 32'h0000_0000);
			i++;
		end while (q[`CSE_STAT_DONE] !== 1'b1 && i < 200);
		check(q[`CSE_STAT_DONE] === 1'b1 && q[`CSE_STAT_BUSY] === 1'b0,
			"done");
		bus(`CSE_OFF_RESULT, 1'b0, 32'h0000_0000);
		check(q[7:0] === exp_code(a), "code");
	endtask : convert
	task conclude;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	initial begin
		void'($urandom(32'h52d0));
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 4; i++) begin
			d = 9'($urandom);
			bus(`CSE_OFF_DECODE, 1'b1, {23'h00_0000, d});
			bus(`CSE_OFF_CTRL, 1'b1, {29'h0000_0000, 2'(i), 1'b0});
			@(posedge sys_clk);
			check({sign_select, chord_select, step_select} === d[7:0], "pins");
			check(encode_select === (i[1] ? d[8] : i[0]), "mode");
			bus(`CSE_OFF_DECODE, 1'b0, 32'h0000_0000);
			check(q === {23'h00_0000, d}, "decode readback");
		end
		foreach (corner[k])
			convert(corner[k]);
		for (int k = 0; k < 8; k++)
			convert(16'($urandom % 17000) - 16'sh2134 | 16'sh0001);
		bus(4'h6, 1'b0, 32'h0000_0000);
		check(q === 32'h0000_0000, "unmapped read");
		conclude();
	end
	// Thirteen conversions need about 1300 cycles
	initial begin
		repeat (30000) @(posedge sys_clk);
		bad_count++;
		conclude();
	end
endmodule : cse_ctrl_tb_top
bind cse_ctrl cse_checker u_cse_checker (.sys_clk, .resetn, .sign_select,
	.chord_select, .step_select, .encode_select, .comparator_high,
	.sample_hold);
